// [ppr_pkg.sv]
// Constants shared by the process regulator and its display scaler
package ppr_pkg;
  // Clock and regulation timing, ADC width
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned PERIOD_MS      = 10;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * PERIOD_MS;
  localparam int unsigned DELAY_UNIT_MS  = 100;
  localparam int unsigned TICKS_PER_UNIT = DELAY_UNIT_MS / PERIOD_MS;
  localparam int unsigned ADC_BITS       = 12;
  // Divider shape
  localparam int unsigned NUM_W     = 58;
  localparam int unsigned DEN_W     = 26;
  localparam int unsigned DIV_STEPS = NUM_W - 1;
  // Register byte offsets
  localparam logic [7:0] A_CONTROL  = 8'h00;
  localparam logic [7:0] A_SETPOINT = 8'h04;
  localparam logic [7:0] A_UPPER    = 8'h08;
  localparam logic [7:0] A_LOWER    = 8'h0c;
  localparam logic [7:0] A_PBAND    = 8'h10;
  localparam logic [7:0] A_ITIME    = 8'h14;
  localparam logic [7:0] A_DTIME    = 8'h18;
  localparam logic [7:0] A_STEP     = 8'h1c;
  localparam logic [7:0] A_SBFREQ   = 8'h20;
  localparam logic [7:0] A_SBDELAY  = 8'h24;
  localparam logic [7:0] A_WAKEUP   = 8'h28;
  localparam logic [7:0] A_SPAN     = 8'h2c;
  localparam logic [7:0] A_DFORMAT  = 8'h30;
  localparam logic [7:0] A_MAXFREQ  = 8'h34;
  localparam logic [7:0] A_STATUS   = 8'h38;
  localparam logic [7:0] A_FREQ     = 8'h3c;
  localparam logic [7:0] A_FEEDBACK = 8'h40;
  localparam logic [7:0] A_DISPLAY  = 8'h44;
  // Field positions
  localparam int unsigned CTRL_POL_BIT = 2;
  localparam int unsigned CTRL_SRC_BIT = 3;
  localparam int unsigned FMT_FRAC_LSB = 4;
  // Fixed point scale and limits, percent in tenths
  localparam logic [15:0] PCT_FULL  = 16'h03e8;
  localparam logic [15:0] PCT_SCALE = 16'h03e9;
  localparam logic [15:0] PB_MAX    = 16'h07d0;
  localparam logic [15:0] TI_MAX    = 16'h07d0;
  localparam logic [15:0] TD_MAX    = 16'h07d0;
  localparam logic [15:0] STEP_MAX  = 16'h0064;
  localparam logic [15:0] SBF_MAX   = 16'h2ee0;
  localparam logic [15:0] SBD_MAX   = 16'h07d0;
  localparam logic [15:0] SPAN_MAX  = 16'h03e8;
  localparam logic [15:0] DIG_MAX   = 16'h0005;
  localparam logic [15:0] FRAC_MAX  = 16'h0004;
  localparam logic [15:0] MAXF_MAX  = 16'h2ee0;
  localparam logic [1:0]  MODE_MAX  = 2'h2;
  // Reset values and the display scaler divisor
  localparam logic [9:0]  RST_UPPER = 10'h3e8;
  localparam logic [10:0] RST_PBAND = 11'h3e8;
  localparam logic [10:0] RST_ITIME = 11'h003;
  localparam logic [6:0]  RST_STEP  = 7'h0a;
  localparam logic [10:0] RST_SBDLY = 11'h064;
  localparam logic [9:0]  RST_SPAN  = 10'h3e8;
  localparam logic [2:0]  RST_DIG   = 3'h4;
  localparam logic [2:0]  RST_FRAC  = 3'h1;
  localparam logic [13:0] RST_MAXF  = 14'h1388;
  localparam logic [16:0] DISP_DIV  = 17'h003e8;
  // Regulator phases
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_APPLY} ppr_state_e;
endpackage

// [ppr_disp_if.sv]
// Link between the regulator core and its display scaler
`timescale 1ns/10ps
interface ppr_disp_if;
  logic [9:0]  pct;
  logic [9:0]  span;
  logic [2:0]  digits;
  logic [2:0]  frac;
  logic [16:0] value;
  logic        shown;
  modport src  (output pct, output span, output digits, output frac,
                input value, input shown);
  modport disp (input pct, input span, input digits, input frac,
                output value, output shown);
endinterface

// [ppr_display.sv]
// Feedback display scaler with digit limit and decimal shift
`timescale 1ns/10ps
module ppr_display (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ppr_disp_if.disp  dsp
);
  import ppr_pkg::*;

  typedef struct packed {
    logic [16:0] value;
    logic        shown;
  } ppr_disp_s;

  ppr_disp_s st;
  ppr_disp_s next_st;
  logic [33:0] scaled;
  logic [33:0] cap;

  // Powers of ten for digit caps and decimal shifts
  function automatic logic [16:0] pow10(input logic [2:0] n);
    case (n)
      3'h0:    pow10 = 17'h00001;
      3'h1:    pow10 = 17'h0000a;
      3'h2:    pow10 = 17'h00064;
      3'h3:    pow10 = 17'h003e8;
      3'h4:    pow10 = 17'h02710;
      default: pow10 = 17'h186a0;
    endcase
  endfunction

  // Span times percent, shifted left by the fraction digits
  always_comb begin
    scaled = (34'(dsp.span) * 34'(dsp.pct) * 34'(pow10(dsp.frac))) / 34'(DISP_DIV); // R13 R15 R16
    cap    = 34'(pow10(dsp.digits)) - 34'h1;
    next_st = st;
    next_st.shown = (dsp.digits != 3'h0); // R14
    if (dsp.digits == 3'h0) begin
      next_st.value = 17'h0;
    end else if (scaled > cap) begin
      next_st.value = cap[16:0]; // R14
    end else begin
      next_st.value = scaled[16:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dsp.value = st.value;
  assign dsp.shown = st.shown;

  a_digit_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    (dsp.digits == 3'h3) |=> (st.value <= 17'h003e7)) // R14
    else $error("display exceeds three digits");
  a_blank_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (dsp.digits == 3'h0) |=> (!st.shown && st.value == 17'h0)) // R14
    else $error("display not blanked");
endmodule // ppr_display

// [ppr_top.sv]
// Process regulator core with Wishbone register slave
//
// Notes on behaviour
// R01: High alarm when feedback above upper threshold.
// R02: Low alarm when feedback below lower threshold.
// R03: Full analog input equals one hundred percent.
// R04: Narrower proportional band gives larger gain.
// R05: Shorter integral time grows integral faster.
// R06: Longer derivative time strengthens change response.
// R07: Regulation evaluated once every ten milliseconds.
// R08: Increment clamped to programmed step limit.
// R09: Standby count starts below standby frequency.
// R10: After delay, stop output, keep monitoring.
// R11: Wake when feedback drops below threshold.
// R12: Wake threshold is set point times percentage.
// R13: Full scale feedback maps to display span.
// R14: Digit count one to five; zero blanks.
// R15: Fraction digits place the decimal point.
// R16: Display equals span times feedback percent.
// R17: Mode zero off, one on, two external.
// R18: Negative mode lowers frequency above set point.
// R19: Tenths of percent, saturate instead of wrap.
// R20: Frequency kept between zero and maximum.
`timescale 1ns/10ps
module ppr_top #(
  parameter int unsigned ADC_W       = ppr_pkg::ADC_BITS,
  parameter int unsigned TICK_CYCLES = ppr_pkg::TICK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [ADC_W-1:0]  voltage_analog_input_i,
  input  wire logic [ADC_W-1:0]  current_analog_input_i,
  input  wire logic              ext_run_i,
  output logic      [13:0]       freq_command_o,
  output logic                   drive_run_o,
  output logic                   upper_alarm_o,
  output logic                   lower_alarm_o,
  output logic                   standby_o,
  output logic      [9:0]        feedback_pct_o,
  output logic      [16:0]       display_value_o,
  output logic                   display_enable_o,
  output logic      [2:0]        display_digits_o,
  output logic      [2:0]        display_point_o
);
  import ppr_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYCLES);

  // Refuse shapes the arithmetic cannot serve
  if (ADC_W < 4 || ADC_W > 16) begin : g_bad_adc
    $error("ADC_W must lie in 4..16");
  end
  if (TICK_CYCLES < DIV_STEPS + 4) begin : g_bad_tick
    $error("TICK_CYCLES too short for the divider");
  end

  typedef struct packed {
    ppr_state_e        state;
    logic              ack;
    logic [31:0]       rdat;
    logic [1:0]        mode;
    logic              pol;
    logic              src;
    logic [9:0]        sp;
    logic [9:0]        up_thr;
    logic [9:0]        lo_thr;
    logic [10:0]       pb;
    logic [10:0]       ti;
    logic [10:0]       td;
    logic [6:0]        step;
    logic [13:0]       sb_freq;
    logic [10:0]       sb_delay;
    logic [9:0]        wake;
    logic [9:0]        span;
    logic [2:0]        digits;
    logic [2:0]        frac;
    logic [13:0]       max_freq;
    logic [ADC_W-1:0]  v_s1;
    logic [ADC_W-1:0]  v_s2;
    logic [ADC_W-1:0]  c_s1;
    logic [ADC_W-1:0]  c_s2;
    logic              x_s1;
    logic              x_s2;
    logic [TW-1:0]     tick_cnt;
    logic              tick;
    logic [9:0]        fb;
    logic              up_al;
    logic              lo_al;
    logic              active;
    logic              standby;
    logic [10:0]       sb_units;
    logic [3:0]        sb_sub;
    logic signed [11:0] e1;
    logic signed [11:0] e2;
    logic signed [11:0] ecur;
    logic              neg;
    logic [DEN_W-1:0]  rem;
    logic [NUM_W-2:0]  quo;
    logic [DEN_W-1:0]  den;
    logic [5:0]        bit_cnt;
    logic [13:0]       freq;
    logic              run;
    logic [13:0]       freq_out;
  } ppr_core_s;

  ppr_core_s st;
  ppr_core_s next_st;

  ppr_disp_if u_disp_if ();

  logic [31:0]             rd;
  logic [31:0]             wv;
  logic                    wb_hit;
  logic signed [11:0]      e_now;
  logic signed [NUM_W-1:0] num;
  logic [NUM_W-2:0]        num_mag;
  logic [14:0]             kti;
  logic [10:0]             pb_eff;
  logic [19:0]             wake_prod;
  logic [9:0]              wake_thr;
  logic [DEN_W:0]          shifted;
  logic [NUM_W-2:0]        inc;
  logic signed [15:0]      f_new;

  // Analog code to tenths of percent; code all ones lands on full scale when ADC_W is 10 or more
  function automatic logic [9:0] to_pct(input logic [ADC_W-1:0] raw);
    logic [ADC_W+9:0] p;
    p = (ADC_W+10)'(raw) * (ADC_W+10)'(PCT_SCALE);
    p = p >> ADC_W;
    to_pct = (p > (ADC_W+10)'(PCT_FULL)) ? PCT_FULL[9:0] : p[9:0]; // R03 R19
  endfunction

  // Byte lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    lane_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        lane_merge[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  endfunction

  // Written values saturate at their upper bound
  function automatic logic [15:0] clampw(input logic [31:0] w, input logic [15:0] mx);
    clampw = (w > {16'h0000, mx}) ? mx : w[15:0]; // R19
  endfunction

  // Register read view, also the base for byte lane merges
  always_comb begin
    rd = 32'h0;
    case (wb_adr_i)
      A_CONTROL:  rd = {28'h0, st.src, st.pol, st.mode};
      A_SETPOINT: rd = {22'h0, st.sp};
      A_UPPER:    rd = {22'h0, st.up_thr};
      A_LOWER:    rd = {22'h0, st.lo_thr};
      A_PBAND:    rd = {21'h0, st.pb};
      A_ITIME:    rd = {21'h0, st.ti};
      A_DTIME:    rd = {21'h0, st.td};
      A_STEP:     rd = {25'h0, st.step};
      A_SBFREQ:   rd = {18'h0, st.sb_freq};
      A_SBDELAY:  rd = {21'h0, st.sb_delay};
      A_WAKEUP:   rd = {22'h0, st.wake};
      A_SPAN:     rd = {22'h0, st.span};
      A_DFORMAT:  rd = {25'h0, st.frac, 1'b0, st.digits};
      A_MAXFREQ:  rd = {18'h0, st.max_freq};
      A_STATUS:   rd = {28'h0, st.active, st.standby, st.lo_al, st.up_al};
      A_FREQ:     rd = {18'h0, st.freq};
      A_FEEDBACK: rd = {22'h0, st.fb};
      A_DISPLAY:  rd = {15'h0, u_disp_if.value};
      default:    rd = 32'h0;
    endcase
  end

  // Regulation arithmetic: increment = gain * (dE + E*T/Ti + Td/T*ddE) scaled to hertz
  always_comb begin
    wv      = lane_merge(rd, wb_dat_i, wb_sel_i);
    wb_hit  = wb_cyc_i && wb_stb_i && !st.ack;
    e_now   = st.pol ? (12'(st.fb) - 12'(st.sp)) : (12'(st.sp) - 12'(st.fb)); // R18
    kti     = (st.ti == 11'h0) ? 15'h1 : 15'(st.ti) * 15'd10;
    pb_eff  = (st.pb == 11'h0) ? 11'h1 : st.pb;
    num     = (NUM_W'(e_now) - NUM_W'(st.e1)
              + NUM_W'($signed({1'b0, st.td})) * (NUM_W'(e_now) - NUM_W'(st.e1)
              - NUM_W'(st.e1) + NUM_W'(st.e2))) * NUM_W'($signed({1'b0, kti})); // R06
    if (st.ti != 11'h0) begin
      num = num + NUM_W'(e_now); // R05
    end
    num     = num * NUM_W'($signed({1'b0, st.max_freq}));
    num_mag = num[NUM_W-1] ? (NUM_W-1)'(-num) : num[NUM_W-2:0];
    wake_prod = 20'(st.sp) * 20'(st.wake);
    wake_thr  = 10'(wake_prod / 20'(PCT_FULL)); // R12
    shifted = {st.rem, st.quo[NUM_W-2]};
    inc     = (st.quo > (NUM_W-1)'(st.step)) ? (NUM_W-1)'(st.step) : st.quo; // R08
    f_new   = st.neg ? (16'(st.freq) - 16'(inc[13:0])) : (16'(st.freq) + 16'(inc[13:0]));
  end

  // Next state of the whole core
  always_comb begin
    next_st = st;
    // Pins cross in through two flops
    next_st.v_s1 = voltage_analog_input_i;
    next_st.v_s2 = st.v_s1;
    next_st.c_s1 = current_analog_input_i;
    next_st.c_s2 = st.c_s1;
    next_st.x_s1 = ext_run_i;
    next_st.x_s2 = st.x_s1;
    next_st.fb    = st.src ? to_pct(st.c_s2) : to_pct(st.v_s2);
    next_st.up_al = (st.fb > st.up_thr); // R01
    next_st.lo_al = (st.fb < st.lo_thr); // R02
    next_st.active = (st.mode == 2'h1) || (st.mode == 2'h2 && st.x_s2); // R17
    // Period divider
    next_st.tick = 1'b0;
    if (st.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1; // R07
    end else begin
      next_st.tick_cnt = st.tick_cnt + TW'(1);
    end
    // Bus slave: answer one cycle after the strobe, writes commit with the answer
    next_st.ack = wb_hit;
    if (wb_hit) begin
      next_st.rdat = rd;
    end
    if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        A_CONTROL: begin
          next_st.mode = (wv[1:0] > MODE_MAX) ? MODE_MAX : wv[1:0];
          next_st.pol  = wv[CTRL_POL_BIT];
          next_st.src  = wv[CTRL_SRC_BIT];
        end
        A_SETPOINT: next_st.sp       = 10'(clampw(wv, PCT_FULL));
        A_UPPER:    next_st.up_thr   = 10'(clampw(wv, PCT_FULL));
        A_LOWER:    next_st.lo_thr   = 10'(clampw(wv, PCT_FULL));
        A_PBAND:    next_st.pb       = 11'(clampw(wv, PB_MAX)); // R04
        A_ITIME:    next_st.ti       = 11'(clampw(wv, TI_MAX));
        A_DTIME:    next_st.td       = 11'(clampw(wv, TD_MAX));
        A_STEP:     next_st.step     = 7'(clampw(wv, STEP_MAX));
        A_SBFREQ:   next_st.sb_freq  = 14'(clampw(wv, SBF_MAX));
        A_SBDELAY:  next_st.sb_delay = 11'(clampw(wv, SBD_MAX));
        A_WAKEUP:   next_st.wake     = 10'(clampw(wv, PCT_FULL));
        A_SPAN:     next_st.span     = 10'(clampw(wv, SPAN_MAX));
        A_DFORMAT: begin
          next_st.digits = 3'(clampw({29'h0, wv[2:0]}, DIG_MAX));
          next_st.frac   = 3'(clampw({29'h0, wv[FMT_FRAC_LSB +: 3]}, FRAC_MAX));
        end
        A_MAXFREQ:  next_st.max_freq = 14'(clampw(wv, MAXF_MAX));
        default: ;
      endcase
    end
    // Regulation phases
    case (st.state)
      S_IDLE: begin
        if (st.tick && st.active && !st.standby) begin
          next_st.ecur    = e_now;
          next_st.neg     = num[NUM_W-1];
          next_st.quo     = num_mag;
          next_st.rem     = '0;
          next_st.den     = DEN_W'(kti) * DEN_W'(pb_eff); // R04 R05
          next_st.bit_cnt = '0;
          next_st.state   = S_DIV;
        end
      end
      S_DIV: begin
        if (shifted >= {1'b0, st.den}) begin
          next_st.rem = DEN_W'(shifted - {1'b0, st.den});
          next_st.quo = {st.quo[NUM_W-3:0], 1'b1};
        end else begin
          next_st.rem = shifted[DEN_W-1:0];
          next_st.quo = {st.quo[NUM_W-3:0], 1'b0};
        end
        next_st.bit_cnt = st.bit_cnt + 6'h1;
        if (st.bit_cnt == 6'(DIV_STEPS - 1)) begin
          next_st.state = S_APPLY;
        end
      end
      S_APPLY: begin
        if (f_new < 16'sh0) begin
          next_st.freq = 14'h0; // R20
        end else if (f_new > $signed({2'b00, st.max_freq})) begin
          next_st.freq = st.max_freq; // R20
        end else begin
          next_st.freq = f_new[13:0];
        end
        next_st.e2    = st.e1;
        next_st.e1    = st.ecur;
        next_st.state = S_IDLE;
      end
      default: next_st.state = S_IDLE;
    endcase
    // Standby entry counts in delay units while running slow
    if (st.tick && st.active && !st.standby) begin
      if (st.freq < st.sb_freq) begin // R09
        if (st.sb_units >= st.sb_delay) begin
          next_st.standby = 1'b1; // R10
          next_st.freq    = 14'h0;
        end else if (st.sb_sub == 4'(TICKS_PER_UNIT - 1)) begin
          next_st.sb_sub   = 4'h0;
          next_st.sb_units = st.sb_units + 11'h1;
        end else begin
          next_st.sb_sub = st.sb_sub + 4'h1;
        end
      end else begin
        next_st.sb_sub   = 4'h0;
        next_st.sb_units = 11'h0;
      end
    end
    // Feedback stays watched in standby; low feedback wakes the loop
    if (st.standby && st.fb < wake_thr) begin
      next_st.standby  = 1'b0; // R11
      next_st.sb_sub   = 4'h0;
      next_st.sb_units = 11'h0;
      next_st.e1       = 12'sh0;
      next_st.e2       = 12'sh0;
    end
    // Loop off: drop history so a restart does not kick on stale error
    if (!st.active) begin
      next_st.state    = S_IDLE; // R17
      next_st.standby  = 1'b0;
      next_st.sb_sub   = 4'h0;
      next_st.sb_units = 11'h0;
      next_st.e1       = 12'sh0;
      next_st.e2       = 12'sh0;
    end
    next_st.run      = st.active && !st.standby; // R10
    next_st.freq_out = st.standby ? 14'h0 : st.freq;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st          <= '0;
      st.state    <= S_IDLE;
      st.up_thr   <= RST_UPPER;
      st.pb       <= RST_PBAND;
      st.ti       <= RST_ITIME;
      st.step     <= RST_STEP;
      st.sb_delay <= RST_SBDLY;
      st.span     <= RST_SPAN;
      st.digits   <= RST_DIG;
      st.frac     <= RST_FRAC;
      st.max_freq <= RST_MAXF;
    end else begin
      st <= next_st;
    end
  end

  assign u_disp_if.pct    = st.fb;
  assign u_disp_if.span   = st.span;
  assign u_disp_if.digits = st.digits;
  assign u_disp_if.frac   = st.frac;

  ppr_display u_display (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dsp   (u_disp_if.disp)
  );

  // Outputs straight from flops
  assign wb_dat_o         = st.rdat;
  assign wb_ack_o         = st.ack;
  assign freq_command_o   = st.freq_out;
  assign drive_run_o      = st.run;
  assign upper_alarm_o    = st.up_al;
  assign lower_alarm_o    = st.lo_al;
  assign standby_o        = st.standby;
  assign feedback_pct_o   = st.fb;
  assign display_value_o  = u_disp_if.value;
  assign display_enable_o = u_disp_if.shown;
  assign display_digits_o = st.digits;
  assign display_point_o  = st.frac;

  a_upper_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
    upper_alarm_o == ($past(st.fb) > $past(st.up_thr))) // R01
    else $error("upper alarm disagrees with feedback");
  a_lower_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
    lower_alarm_o == ($past(st.fb) < $past(st.lo_thr))) // R02
    else $error("lower alarm disagrees with feedback");
  a_eval_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.state == S_DIV) |-> $past(st.tick)) // R07
    else $error("evaluation started off the period");
  a_step_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(st.state == S_APPLY) |-> (st.freq <= $past(st.freq) + 14'($past(st.step)))
      && (st.freq + 14'($past(st.step)) >= $past(st.freq))) // R08
    else $error("frequency moved beyond the step limit");
  a_freq_range: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(st.state == S_APPLY) |-> (st.freq <= $past(st.max_freq))) // R20
    else $error("frequency above maximum");
  a_standby_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    st.standby |=> (freq_command_o == 14'h0 && !drive_run_o)) // R10
    else $error("output not stopped in standby");
  a_wake_resume: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.standby && st.fb < wake_thr) |=> !st.standby ##1 drive_run_o || !st.active) // R11
    else $error("standby did not wake");
  a_mode_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.mode == 2'h0) [*2] |-> !st.active ##1 !drive_run_o) // R17
    else $error("regulation active in mode zero");
  a_standby_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.standby) |-> $past(st.sb_units) >= $past(st.sb_delay)
      && $past(st.freq) < $past(st.sb_freq)) // R09
    else $error("standby entered before its delay");
endmodule // ppr_top

// [ppr_sensor_model.sv]
// Behavioural process sensor feeding both analog channels of the regulator
`timescale 1ns/10ps
module ppr_sensor_model #(
  parameter int unsigned ADC_W = 12
) (
  input  wire logic [9:0]       level_i,
  output logic      [ADC_W-1:0] volt_o,
  output logic      [ADC_W-1:0] curr_o
);
  int unsigned code;
  int unsigned code_c;
  // Full scale level maps to the all-ones code, so the top code reads as 100 percent
  // Current channel carries the complement so the source select can be seen
  always_comb begin
    code = level_i * (1 << ADC_W) / 1000;
    if (code > (1 << ADC_W) - 1) begin
      code = (1 << ADC_W) - 1;
    end
    code_c = (level_i >= 10'd1000) ? 0 : (1000 - level_i) * (1 << ADC_W) / 1000;
    if (code_c > (1 << ADC_W) - 1) begin
      code_c = (1 << ADC_W) - 1;
    end
    volt_o = code[ADC_W-1:0];
    curr_o = code_c[ADC_W-1:0];
  end
endmodule // ppr_sensor_model

// [testbench.sv]
// Self-checking bench for the process regulator
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  $display("Error %s expected %h seen %h", nm, ex, got); n_fail++; end end
module testbench;
  import ppr_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ext_run = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic [9:0] level = 10'h0, fb_pct;
  logic [11:0] volt, curr;
  logic [13:0] freq, f0;
  logic [16:0] disp;
  logic [2:0] digs, pnt;
  logic wb_ack_o, run, up, lo, sby, den;
  int n_fail = 0, samples_checked = 0, n;
  always #20 clk_i = ~clk_i;
  ppr_sensor_model #(.ADC_W(12)) ppr_sensor_model_i (.level_i(level), .volt_o(volt),
    .curr_o(curr));
  ppr_top #(.ADC_W(12), .TICK_CYCLES(100)) ppr_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .voltage_analog_input_i(volt), .current_analog_input_i(curr), .ext_run_i(ext_run),
    .freq_command_o(freq), .drive_run_o(run), .upper_alarm_o(up), .lower_alarm_o(lo),
    .standby_o(sby), .feedback_pct_o(fb_pct), .display_value_o(disp),
    .display_enable_o(den), .display_digits_o(digs), .display_point_o(pnt));
  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    // A missing answer is a failure, not a silent fall-through
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
    end
    rd = wb_dat_o;
    cyc <= 1'b0; we <= 1'b0;
  endtask
  // Waits for the next evaluation to move the command, bounded
  task automatic wait_freq();
    f0 = freq;
    n = 0;
    while (freq === f0 && n < 400) begin @(posedge clk_i); n++; end
    if (freq === f0) begin
      n_fail++;
    end
  endtask
  task automatic t_reset();
    logic [7:0] a [8] = '{A_UPPER, A_PBAND, A_ITIME, A_STEP, A_SBDELAY, A_SPAN, A_DFORMAT, 8'h80};
    logic [31:0] e [8] = '{32'h3e8, 32'h3e8, 32'h3, 32'ha, 32'h64, 32'h3e8, 32'h14, 32'h0};
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, a[i], 32'h0);
      `CHK("reset read", e[i], rd)
    end
  endtask
  task automatic t_alarm();
    level <= 10'h3e8;
    wb(1'b1, A_UPPER, 32'h1f4);
    repeat (8) @(posedge clk_i);
    `CHK("fb pct", 10'h3e8, fb_pct)
    `CHK("upper", 1'b1, up)
    level <= 10'h0;
    wb(1'b1, A_LOWER, 32'h12c);
    repeat (8) @(posedge clk_i);
    `CHK("lower", 1'b1, lo)
    `CHK("upper off", 1'b0, up)
  endtask
  task automatic t_display();
    level <= 10'h1f4;
    wb(1'b1, A_SPAN, 32'hc8);
    repeat (8) @(posedge clk_i);
    `CHK("display", 17'h3e8, disp)
    `CHK("disp en", 1'b1, den)
    `CHK("digits", 3'h4, digs)
    `CHK("point", 3'h1, pnt)
    wb(1'b1, A_DFORMAT, 32'h24);
    repeat (8) @(posedge clk_i);
    `CHK("display cap", 17'h270f, disp)
    `CHK("point 2", 3'h2, pnt)
    wb(1'b1, A_DFORMAT, 32'h23);
    repeat (8) @(posedge clk_i);
    `CHK("three digit cap", 17'h3e7, disp)
    wb(1'b1, A_DFORMAT, 32'h10);
    repeat (8) @(posedge clk_i);
    `CHK("disp blank", 1'b0, den)
  endtask
  // Feedback far below set point must raise frequency by the step limit each period
  task automatic t_regulate();
    level <= 10'h0;
    wb(1'b1, A_SETPOINT, 32'h3e8);
    wb(1'b1, A_CONTROL, 32'h1);
    wait_freq();
    `CHK("freq 1", 14'ha, freq)
    wait_freq();
    `CHK("freq 2", 14'h14, freq)
    wb(1'b1, A_CONTROL, 32'h2);
    repeat (300) @(posedge clk_i);
    `CHK("held ext low", 14'h14, freq)
    ext_run <= 1'b1;
    wait_freq();
    `CHK("ext run", 14'h1e, freq)
  endtask
  // Wide band, then short integral time, each judged on one increment
  task automatic t_gain();
    wb(1'b1, A_STEP, 32'h1ff);
    wb(1'b0, A_STEP, 32'h0);
    `CHK("step saturate", 32'h64, rd)
    wb(1'b1, A_CONTROL, 32'h0);
    wb(1'b1, A_SETPOINT, 32'ha);
    wb(1'b1, A_PBAND, 32'h7d0);
    wb(1'b1, A_CONTROL, 32'h1);
    wait_freq();
    `CHK("wide band", 14'h37, freq)
    wb(1'b1, A_ITIME, 32'h1);
    wb(1'b1, A_SETPOINT, 32'h64);
    wait_freq();
    `CHK("error jump", 14'h9b, freq)
    wait_freq();
    `CHK("short integral", 14'hb4, freq)
  endtask
  // Positive sense lowers the command; current source reads the complemented channel
  task automatic t_polar();
    wb(1'b1, A_CONTROL, 32'h5);
    wait_freq();
    `CHK("positive sense", 14'h50, freq)
    wb(1'b1, A_CONTROL, 32'hd);
    repeat (8) @(posedge clk_i);
    `CHK("current source", 10'h3e8, fb_pct)
    wb(1'b1, A_CONTROL, 32'h2);
  endtask
  // Zero delay sleeps on first slow tick; full wake percentage wakes at once
  task automatic t_standby();
    wb(1'b1, A_SBDELAY, 32'h0);
    wb(1'b1, A_SBFREQ, 32'h2ee0);
    n = 0;
    while (sby !== 1'b1 && n < 400) begin @(posedge clk_i); n++; end
    @(posedge clk_i);
    `CHK("standby", 1'b1, sby)
    `CHK("stop freq", 14'h0, freq)
    `CHK("stop run", 1'b0, run)
    wb(1'b1, A_WAKEUP, 32'h3e8);
    n = 0;
    while (sby !== 1'b0 && n < 10) begin @(posedge clk_i); n++; end
    `CHK("wake", 1'b0, sby)
  endtask
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_alarm();
    t_display();
    t_regulate();
    t_gain();
    t_polar();
    t_standby();
    test_done();
  end
  // Watchdog well beyond the fewer than two thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    test_done();
  end
endmodule // testbench
